// File: inc/lcdh_pkg.sv
// constants, types and command decoding of the lcd host command unit
// Notes on behaviour
// - idle reset pin level picks the bus: high gives 68-style, low 80-style
// - chip select high ignores bus cycles, reset pin still acts
// - select line 1 means display data, 0 means status read or command write
// - 68-style: enable plus direction; 80-style: separate low read and store strobes
// - display read returns latch contents while the ram byte loads the latch
// - display writes need no dummy cycle and go straight to ram
// - while busy every command except status read is rejected
// - status: busy D7, mirror D6, blank D5, resetting D4, zero below
// - every frame signal edge copies start line into line count
// - line count advances by one on each line clock
// - column counter steps by one on each display write, and on each display read outside rmw
// - column counter stops at 50H, page never changes
// - set-page command loads the two-bit page register
// - duty command: D0 one gives 1/32, zero gives 1/16
// - either edge on the reset pin starts initialisation
// - init: off, start line 1, static off, column 0, page 3, 1/32, forward, no rmw
// - start-line command loads the five-bit start line
// - command byte with D7 zero loads the column counter
// - display on/off command sets display on from D0
// - direction command sets mapping, mirror status is inverse of D0
// - static-drive command selects static drive from D0
// - read-modify-write saves column and stops read stepping
// - end command leaves rmw and restores the saved column
// - software reset clears start line and sets page 3, ram kept
package lcdh_pkg;
	localparam int DATA_W = 8;
	localparam int COL_W = 7;
	localparam int PAGE_W = 2;
	localparam int LINE_W = 5;
	localparam int CNT_W = 8;
	localparam int RAM_AW = PAGE_W + COL_W;
	localparam logic [COL_W-1:0] COL_LIMIT = 7'h50;
	localparam logic [COL_W-1:0] INIT_COL = 7'h00;
	localparam logic [PAGE_W-1:0] INIT_PAGE = 2'h3;
	localparam logic [LINE_W-1:0] INIT_START = 5'h01;
	localparam logic [LINE_W-1:0] SWRST_START = 5'h00;
	localparam logic INIT_DUTY_32 = 1'b1;
	localparam logic INIT_ADC = 1'b0;
	localparam int EXEC_CYCLES = 2;
	localparam int INIT_CYCLES = 8;
	localparam int ST_BUSY_BIT = 7;
	localparam int ST_MIRROR_BIT = 6;
	localparam int ST_BLANK_BIT = 5;
	localparam int ST_RESET_BIT = 4;
	localparam logic [7:0] OP_ONOFF = 8'hAE;
	localparam logic [7:0] OP_ADC = 8'hA0;
	localparam logic [7:0] OP_STATIC = 8'hA4;
	localparam logic [7:0] OP_DUTY = 8'hA8;
	localparam logic [7:0] OP_PAGE = 8'hB8;
	localparam logic [7:0] OP_START = 8'hC0;
	localparam logic [7:0] OP_RMW = 8'hE0;
	localparam logic [7:0] OP_SWRST = 8'hE2;
	localparam logic [7:0] OP_END = 8'hEE;

	typedef enum {CMD_NONE, CMD_COL, CMD_START, CMD_PAGE, CMD_ONOFF, CMD_ADC,
		CMD_STATIC, CMD_DUTY, CMD_RMW, CMD_END, CMD_SWRST} lcdh_cmd_type;
	typedef enum {ST_IDLE, ST_EXEC, ST_INIT} lcdh_state_type;

	// sort a command byte into its kind
	function automatic lcdh_cmd_type lcdh_decode(input logic [7:0] b);
		lcdh_cmd_type c;
		c = CMD_NONE;
		if (!b[7]) c = CMD_COL;
		else if (b[7:5] == OP_START[7:5]) c = CMD_START;
		else if (b[7:2] == OP_PAGE[7:2]) c = CMD_PAGE;
		else if (b[7:1] == OP_ONOFF[7:1]) c = CMD_ONOFF;
		else if (b[7:1] == OP_ADC[7:1]) c = CMD_ADC;
		else if (b[7:1] == OP_STATIC[7:1]) c = CMD_STATIC;
		else if (b[7:1] == OP_DUTY[7:1]) c = CMD_DUTY;
		else if (b == OP_RMW) c = CMD_RMW;
		else if (b == OP_END) c = CMD_END;
		else if (b == OP_SWRST) c = CMD_SWRST;
		return c;
	endfunction : lcdh_decode
endpackage : lcdh_pkg

// File: src/lcdh_edge.sv
// synchronous edge sensing of level inputs
`timescale 1ns/1ps
module lcdh_edge #(
	parameter int W = 1
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [W-1:0] level_i,
	output logic [W-1:0] rise_o,
	output logic [W-1:0] fall_o
);
	logic [W-1:0] prev_q, prev_d;
	logic armed_q, armed_d;

	// the first cycle after reset only samples, so no false edge is seen
	always_comb begin
		prev_d = level_i;
		armed_d = 1'b1;
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			prev_q <= '0;
			armed_q <= 1'b0;
		end else begin
			prev_q <= prev_d;
			armed_q <= armed_d;
		end
	end

	// edges against the previous sample
	assign rise_o = armed_q ? (level_i & ~prev_q) : '0;
	assign fall_o = armed_q ? (~level_i & prev_q) : '0;
endmodule : lcdh_edge

// File: src/lcdh_ram.sv
// display data ram with registered read port
`timescale 1ns/1ps
module lcdh_ram #(
	parameter int AW = 9,
	parameter int DW = 8
) (
	input wire logic clk_sys_i,
	input wire logic we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [DW-1:0] wdata_i,
	output logic [DW-1:0] rdata_o
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic [DW-1:0] rdata_q;

	// contents survive every reset, only the host changes them
	always_ff @(posedge clk_sys_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
		rdata_q <= mem[addr_i];
	end

	assign rdata_o = rdata_q;
endmodule : lcdh_ram

// File: src/lcdh_top.sv
// host bus port, command decoder and ram addressing of the lcd driver
`timescale 1ns/1ps
module lcdh_top import lcdh_pkg::*; #(
	parameter int EXEC_CNT = EXEC_CYCLES,
	parameter int INIT_CNT = INIT_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic init_pin_polarity_i, // reset pin level
	input wire logic chip_sel_n_i,
	input wire logic cmd_or_pixel_select_i,
	input wire logic enable_rd_i, // 68: enable strobe, 80: read_strobe_n
	input wire logic dir_wr_i, // 68: direction_select, 80: store_strobe_n
	input wire logic [DATA_W-1:0] data_i,
	input wire logic row_tick_i,
	input wire logic lcd_polarity_alt_i,
	output logic [DATA_W-1:0] data_o,
	output logic data_oe_o,
	output logic bus_80_mode_o,
	output logic busy_o,
	output logic resetting_o,
	output logic display_on_o,
	output logic static_drive_o,
	output logic duty_32_o,
	output logic segment_mirror_o,
	output logic rmw_o,
	output logic [LINE_W-1:0] start_line_o,
	output logic [LINE_W-1:0] line_count_o,
	output logic [PAGE_W-1:0] page_o,
	output logic [COL_W-1:0] column_o
);
	logic [2:0] rise, fall;
	logic pin_edge, pol_edge, tick_rise;
	logic rd_act, wr_act, rd_done, wr_done;
	logic rd_prev_q, wr_prev_q, sel_q, sel_d;
	logic m80_q, m80_d, strap_q;
	lcdh_state_type st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic on_q, on_d, stat_q, stat_d, duty_q, duty_d;
	logic adc_q, adc_d, rmw_q, rmw_d; // adc_q holds the mirror status flag
	logic busy_q, busy_d, rstf_q, rstf_d, oe_q, oe_d;
	logic [LINE_W-1:0] start_q, start_d, line_q, line_d;
	logic [PAGE_W-1:0] page_q, page_d;
	logic [COL_W-1:0] col_q, col_d, save_q, save_d;
	logic [DATA_W-1:0] wlat_q, wlat_d, olat_q, olat_d, dat_q, dat_d;
	logic [DATA_W-1:0] ram_rdata;
	logic ram_we;
	lcdh_cmd_type cmd;

	// next column after a display access, held at the limit
	function automatic logic [COL_W-1:0] col_step(input logic [COL_W-1:0] c);
		return (c < COL_LIMIT) ? c + 7'h01 : c;
	endfunction : col_step

	// edges of reset pin, frame signal and line clock
	lcdh_edge #(
		.W(3)
	) u_edge (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.level_i({init_pin_polarity_i, lcd_polarity_alt_i, row_tick_i}),
		.rise_o(rise),
		.fall_o(fall)
	);

	assign pin_edge = rise[2] | fall[2];
	assign pol_edge = rise[1] | fall[1];
	assign tick_rise = rise[0];

	// display ram addressed by page and column
	lcdh_ram #(
		.AW(RAM_AW),
		.DW(DATA_W)
	) u_ram (
		.clk_sys_i(clk_sys_i),
		.we_i(ram_we),
		.addr_i({page_q, col_q}),
		.wdata_i(wlat_q),
		.rdata_o(ram_rdata)
	);

	// bus cycle decode for the selected bus style
	always_comb begin
		if (m80_q) begin
			rd_act = !chip_sel_n_i && !enable_rd_i;
			wr_act = !chip_sel_n_i && !dir_wr_i;
		end else begin
			rd_act = !chip_sel_n_i && enable_rd_i && dir_wr_i;
			wr_act = !chip_sel_n_i && enable_rd_i && !dir_wr_i;
		end
	end

	// a cycle takes effect when its strobe ends
	assign rd_done = rd_prev_q && !rd_act;
	assign wr_done = wr_prev_q && !wr_act;

	// bus style from the pin level: high (active-low reset) is 68-style, low is 80-style
	always_comb begin
		m80_d = m80_q;
		if (strap_q || pin_edge) begin
			m80_d = !init_pin_polarity_i;
		end
		sel_d = (rd_act || wr_act) ? cmd_or_pixel_select_i : sel_q;
		wlat_d = wr_act ? data_i : wlat_q;
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			m80_q <= 1'b0;
			strap_q <= 1'b1;
			rd_prev_q <= 1'b0;
			wr_prev_q <= 1'b0;
			sel_q <= 1'b0;
			wlat_q <= 8'h00;
		end else begin
			m80_q <= m80_d;
			strap_q <= 1'b0;
			rd_prev_q <= rd_act;
			wr_prev_q <= wr_act;
			sel_q <= sel_d;
			wlat_q <= wlat_d;
		end
	end

	// command execution, display access and line counting
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		on_d = on_q;
		stat_d = stat_q;
		duty_d = duty_q;
		adc_d = adc_q;
		rmw_d = rmw_q;
		start_d = start_q;
		line_d = line_q;
		page_d = page_q;
		col_d = col_q;
		save_d = save_q;
		olat_d = olat_q;
		ram_we = 1'b0;
		cmd = lcdh_decode(wlat_q);
		if (pol_edge) begin
			line_d = start_q;
		end else if (tick_rise) begin
			line_d = line_q + 5'h01;
		end
		if (st_q != ST_IDLE) begin
			if (cnt_q == '0) begin
				st_d = ST_IDLE;
			end else begin
				cnt_d = cnt_q - 8'h01;
			end
		end
		if (pin_edge) begin
			on_d = 1'b0;
			start_d = INIT_START;
			stat_d = 1'b0;
			col_d = INIT_COL;
			page_d = INIT_PAGE;
			duty_d = INIT_DUTY_32;
			adc_d = !INIT_ADC;
			rmw_d = 1'b0;
			st_d = ST_INIT;
			cnt_d = CNT_W'(INIT_CNT - 1);
		end else if (st_q == ST_IDLE) begin
			if (wr_done && sel_q) begin
				ram_we = col_q < COL_LIMIT;
				col_d = col_step(col_q);
			end else if (rd_done && sel_q) begin
				olat_d = ram_rdata;
				if (!rmw_q) begin
					col_d = col_step(col_q);
				end
			end else if (wr_done) begin
				st_d = ST_EXEC;
				cnt_d = CNT_W'(EXEC_CNT - 1);
				case (cmd)
					CMD_COL: begin
						col_d = (wlat_q[6:0] > COL_LIMIT) ? COL_LIMIT : wlat_q[6:0];
					end
					CMD_START: begin
						start_d = wlat_q[4:0];
					end
					CMD_PAGE: begin
						page_d = wlat_q[1:0];
					end
					CMD_ONOFF: begin
						on_d = wlat_q[0];
					end
					CMD_ADC: begin
						adc_d = !wlat_q[0];
					end
					CMD_STATIC: begin
						stat_d = wlat_q[0];
					end
					CMD_DUTY: begin
						duty_d = wlat_q[0];
					end
					CMD_RMW: begin
						rmw_d = 1'b1;
						save_d = col_q;
					end
					CMD_END: begin
						rmw_d = 1'b0;
						if (rmw_q) begin
							col_d = save_q;
						end
					end
					CMD_SWRST: begin
						start_d = SWRST_START;
						page_d = INIT_PAGE;
						st_d = ST_INIT;
						cnt_d = CNT_W'(INIT_CNT - 1);
					end
					default: begin
					end
				endcase
			end
		end
		busy_d = st_d != ST_IDLE;
		rstf_d = st_d == ST_INIT;
		oe_d = rd_act;
		if (cmd_or_pixel_select_i) begin
			dat_d = olat_q;
		end else begin
			dat_d = 8'h00;
			dat_d[ST_BUSY_BIT] = busy_q;
			dat_d[ST_MIRROR_BIT] = adc_q;
			dat_d[ST_BLANK_BIT] = !on_q;
			dat_d[ST_RESET_BIT] = rstf_q;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			st_q <= ST_IDLE;
			cnt_q <= '0;
			on_q <= 1'b0;
			stat_q <= 1'b0;
			duty_q <= INIT_DUTY_32;
			adc_q <= !INIT_ADC;
			rmw_q <= 1'b0;
			start_q <= INIT_START;
			line_q <= 5'h00;
			page_q <= INIT_PAGE;
			col_q <= INIT_COL;
			save_q <= INIT_COL;
			olat_q <= 8'h00;
			busy_q <= 1'b0;
			rstf_q <= 1'b0;
			oe_q <= 1'b0;
			dat_q <= 8'h00;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			on_q <= on_d;
			stat_q <= stat_d;
			duty_q <= duty_d;
			adc_q <= adc_d;
			rmw_q <= rmw_d;
			start_q <= start_d;
			line_q <= line_d;
			page_q <= page_d;
			col_q <= col_d;
			save_q <= save_d;
			olat_q <= olat_d;
			busy_q <= busy_d;
			rstf_q <= rstf_d;
			oe_q <= oe_d;
			dat_q <= dat_d;
		end
	end

	// outputs straight from the registers
	assign data_o = dat_q;
	assign data_oe_o = oe_q;
	assign bus_80_mode_o = m80_q;
	assign busy_o = busy_q;
	assign resetting_o = rstf_q;
	assign display_on_o = on_q;
	assign static_drive_o = stat_q;
	assign duty_32_o = duty_q;
	assign segment_mirror_o = adc_q;
	assign rmw_o = rmw_q;
	assign start_line_o = start_q;
	assign line_count_o = line_q;
	assign page_o = page_q;
	assign column_o = col_q;

	// checks on the behaviour above
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	col_range_a: assert property (column_o <= COL_LIMIT)
		else $error("column counter beyond limit");
	col_step_a: assert property (
		st_q == ST_IDLE && !pin_edge && wr_done && sel_q && col_q < COL_LIMIT
		|=> column_o == $past(col_q) + 7'h01)
		else $error("column did not step after data write");
	rmw_hold_a: assert property (
		st_q == ST_IDLE && !pin_edge && rd_done && sel_q && rmw_q |=> $stable(col_q))
		else $error("column stepped on read in rmw mode");
	busy_reject_a: assert property (
		busy_q && wr_done && !sel_q && !pin_edge |=> $stable(start_q) && $stable(page_q))
		else $error("command taken while busy");
	read_latch_a: assert property (
		st_q == ST_IDLE && !pin_edge && rd_done && sel_q |=> olat_q == $past(ram_rdata))
		else $error("read latch not loaded from ram");
	bus_drive_a: assert property (data_oe_o
		|-> $past(!chip_sel_n_i && (bus_80_mode_o ? !enable_rd_i : enable_rd_i && dir_wr_i)))
		else $error("bus driven outside a read");
	cs_detach_a: assert property (chip_sel_n_i [*2] |-> !data_oe_o)
		else $error("bus driven while deselected");
	status_fmt_a: assert property (
		data_oe_o && !$past(cmd_or_pixel_select_i)
		|-> data_o[3:0] == 4'h0 && data_o[7] == $past(busy_q) && data_o[5] == !$past(on_q))
		else $error("status byte malformed");
	frame_copy_a: assert property (pol_edge |=> line_count_o == $past(start_q))
		else $error("line count not loaded at frame edge");
	line_tick_a: assert property (
		tick_rise && !pol_edge |=> line_count_o == $past(line_q) + 5'h01)
		else $error("line count did not advance");
	pin_init_a: assert property (
		pin_edge |=> page_o == INIT_PAGE && column_o == INIT_COL && duty_32_o
		&& !display_on_o && resetting_o && !rmw_o)
		else $error("initialisation state wrong");
	bus_mode_a: assert property (
		pin_edge |=> bus_80_mode_o == !$past(init_pin_polarity_i))
		else $error("bus style not taken from reset pin");

	data_write_c: cover property (wr_done && sel_q && st_q == ST_IDLE);
	data_read_c: cover property (rd_done && sel_q && st_q == ST_IDLE && rmw_q);
	rmw_end_c: cover property (rmw_q ##[1:50] !rmw_q);
	pin_reset_c: cover property (pin_edge ##1 resetting_o [*3]);
endmodule : lcdh_top

// File: test/lcdh_host_model.sv
// host processor model that drives the bus of the lcd unit
`timescale 1ns/1ps
module lcdh_host_model (
	input wire logic clk_sys_i,
	input wire logic mode_80_i,
	input wire logic data_oe_i,
	input wire logic [7:0] data_i,
	output logic chip_sel_n_o,
	output logic select_o,
	output logic enable_rd_o,
	output logic dir_wr_o,
	output logic [7:0] data_o
);
	logic tmo = 1'b0;
	// idle bus with the chip deselected
	initial begin
		chip_sel_n_o = 1'b1;
		select_o = 1'b0;
		enable_rd_o = 1'b1;
		dir_wr_o = 1'b1;
		data_o = 8'h00;
	end
	// one cycle, held until a read answer is sampled, then released
	task automatic cyc(input logic rd, input logic sel, input logic [7:0] wd,
		input logic off, output logic [7:0] rv);
		int n;
		chip_sel_n_o <= off;
		select_o <= sel;
		enable_rd_o <= mode_80_i ? !rd : 1'b1;
		dir_wr_o <= rd;
		data_o <= rd ? ~data_o : wd;
		n = 0;
		@(posedge clk_sys_i);
		while (rd && !off && data_oe_i !== 1'b1 && n < 8) begin
			@(posedge clk_sys_i);
			n++;
		end
		tmo = tmo | (n == 8);
		rv = data_i;
		chip_sel_n_o <= 1'b1;
		enable_rd_o <= mode_80_i;
		dir_wr_o <= 1'b1;
		data_o <= ~data_o; // released line shows the inverse
		@(posedge clk_sys_i);
	endtask : cyc
endmodule : lcdh_host_model

// File: test/test_lcdh_top.sv
// self-checking bench for the lcd host command unit
`timescale 1ns/1ps
module test_lcdh_top import lcdh_pkg::*; ;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic init_pin_polarity_i = 1'b0;
	logic row_tick_i = 1'b0;
	logic lcd_polarity_alt_i = 1'b0;
	logic mode_80 = 1'b1;
	logic chip_sel_n_i, cmd_or_pixel_select_i, enable_rd_i, dir_wr_i, data_oe_o, bus_80_mode_o;
	logic busy_o, resetting_o, display_on_o, static_drive_o, duty_32_o, segment_mirror_o, rmw_o;
	logic [DATA_W-1:0] data_i, data_o, host_d;
	logic [LINE_W-1:0] start_line_o, line_count_o;
	logic [PAGE_W-1:0] page_o;
	logic [COL_W-1:0] column_o;
	int miscompares = 0;
	int num_checks = 0;
	logic [7:0] cmds [10] = '{8'hAF, 8'hA1, 8'hA5, 8'hA4, 8'hA8, 8'hA9, 8'hA0, 8'hB9, 8'hD7, 8'hE2};
	logic [15:0] exps [10] = '{16'hB61, 16'hA61, 16'hE61, 16'hA61, 16'h861, 16'hA61, 16'hB61,
		16'hB21, 16'hB37, 16'hB60};

	lcdh_top #(.EXEC_CNT(12), .INIT_CNT(8)) uut (.clk_sys_i, .rst_i, .init_pin_polarity_i,
		.chip_sel_n_i, .cmd_or_pixel_select_i, .enable_rd_i, .dir_wr_i, .data_i, .row_tick_i,
		.lcd_polarity_alt_i, .data_o, .data_oe_o, .bus_80_mode_o, .busy_o, .resetting_o,
		.display_on_o, .static_drive_o, .duty_32_o, .segment_mirror_o, .rmw_o, .start_line_o,
		.line_count_o, .page_o, .column_o);
	lcdh_host_model host (.clk_sys_i, .mode_80_i(mode_80), .data_oe_i(data_oe_o), .data_i,
		.chip_sel_n_o(chip_sel_n_i), .select_o(cmd_or_pixel_select_i), .enable_rd_o(enable_rd_i),
		.dir_wr_o(dir_wr_i), .data_o(host_d));

	// shared data wire: the unit wins while it drives
	assign data_i = data_oe_o ? data_o : host_d;
	// 200 MHz clock
	always #2.5 clk_sys_i = ~clk_sys_i;

	// print counts and verdict, then stop
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : summarize
	// compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one host cycle; a hung read ends the run
	task automatic bus(input logic rd, input logic sel, input logic [7:0] wd, input logic off,
		output logic [7:0] rv);
		host.cyc(rd, sel, wd, off, rv);
		if (host.tmo) begin
			miscompares++;
			summarize();
		end
	endtask : bus
	// wait for busy to drop, bounded
	task automatic idle();
		int n;
		n = 0;
		repeat (2) @(posedge clk_sys_i);
		while (busy_o !== 1'b0) begin
			@(posedge clk_sys_i);
			n++;
			if (n > 200) begin
				miscompares++;
				summarize();
			end
		end
	endtask : idle
	task automatic wr(input logic sel, input logic [7:0] wd);
		logic [7:0] rv;
		bus(1'b0, sel, wd, 1'b0, rv);
		idle();
	endtask : wr
	task automatic rd(input logic sel, output logic [7:0] v);
		bus(1'b1, sel, 8'h00, 1'b0, v);
		idle();
	endtask : rd
	task automatic fin(input string s);
		$display("%s test done", s);
	endtask : fin
	// mode flags packed for one compare
	function automatic logic [15:0] flags();
		return 16'({display_on_o, static_drive_o, duty_32_o, segment_mirror_o, rmw_o, page_o,
			start_line_o});
	endfunction : flags

	// main sequence
	initial begin
		logic [7:0] v;
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		chk(16'(bus_80_mode_o), 16'h1);
		chk(flags(), 16'h361);
		chk(16'(column_o), 16'h0);
		rd(1'b0, v);
		chk(16'(v), 16'h60);
		fin("reset");
		for (int i = 0; i < 10; i++) begin
			wr(1'b0, cmds[i]);
			chk(flags(), exps[i]);
		end
		fin("commands");
		wr(1'b0, 8'h10);
		wr(1'b1, 8'hAA);
		wr(1'b1, 8'h55);
		chk(16'(column_o), 16'h12);
		wr(1'b0, 8'h10);
		rd(1'b1, v);
		rd(1'b1, v);
		chk(16'(v), 16'hAA);
		rd(1'b1, v);
		chk(16'(v), 16'h55);
		chk(16'(column_o), 16'h13);
		fin("data");
		wr(1'b0, 8'h4F);
		wr(1'b1, 8'h11);
		wr(1'b1, 8'h22);
		chk(16'({page_o, column_o}), 16'h1D0);
		wr(1'b0, 8'h7F);
		chk(16'(column_o), 16'h50);
		wr(1'b0, 8'h4F);
		rd(1'b1, v);
		rd(1'b1, v);
		chk(16'(v), 16'h11);
		fin("limit");
		wr(1'b0, 8'h20);
		wr(1'b0, 8'hE0);
		rd(1'b1, v);
		rd(1'b1, v);
		chk(16'({rmw_o, column_o}), 16'hA0);
		wr(1'b1, 8'h33);
		chk(16'(column_o), 16'h21);
		wr(1'b0, 8'hEE);
		chk(16'({rmw_o, column_o}), 16'h20);
		fin("rmw");
		bus(1'b0, 1'b0, 8'hAE, 1'b0, v);
		bus(1'b0, 1'b0, 8'hAF, 1'b0, v);
		bus(1'b1, 1'b0, 8'h00, 1'b0, v);
		chk(16'(v), 16'hE0);
		idle();
		chk(16'(display_on_o), 16'h0);
		bus(1'b0, 1'b0, 8'hAF, 1'b1, v);
		idle();
		chk(16'({display_on_o, data_oe_o}), 16'h0);
		fin("busy");
		wr(1'b0, 8'hC5);
		lcd_polarity_alt_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		chk(16'(line_count_o), 16'h5);
		row_tick_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		row_tick_i <= 1'b0;
		chk(16'(line_count_o), 16'h6);
		lcd_polarity_alt_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		chk(16'(line_count_o), 16'h5);
		fin("frame");
		init_pin_polarity_i <= 1'b1;
		mode_80 <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		chk(16'({busy_o, resetting_o}), 16'h3);
		idle();
		chk(16'(bus_80_mode_o), 16'h0);
		chk(flags(), 16'h361);
		chk(16'(column_o), 16'h0);
		wr(1'b0, 8'hAF);
		rd(1'b0, v);
		chk(16'(v), 16'h40);
		wr(1'b0, 8'h05);
		wr(1'b1, 8'h5A);
		wr(1'b0, 8'h05);
		rd(1'b1, v);
		rd(1'b1, v);
		chk(16'(v), 16'h5A);
		fin("mode");
		summarize();
	end
endmodule : test_lcdh_top
